//--- hw/gpc_pkg.sv
// constants for the gpio pin configuration and data block
package gpc_pkg;
    // register indices (byte address is index * 4, so every offset is a multiple of four)
    localparam logic [7:0] GPC_IDX_P53_CFG  = 8'h42;
    localparam logic [7:0] GPC_IDX_P54_CFG  = 8'h43;
    localparam logic [7:0] GPC_IDX_P55_CFG  = 8'h44;
    localparam logic [7:0] GPC_IDX_P56_CFG  = 8'h45;
    localparam logic [7:0] GPC_IDX_P57_CFG  = 8'h46;
    localparam logic [7:0] GPC_IDX_P60_CFG  = 8'h47;
    localparam logic [7:0] GPC_IDX_P61_CFG  = 8'h48;
    localparam logic [7:0] GPC_IDX_RSVD_A   = 8'h49;
    localparam logic [7:0] GPC_IDX_RSVD_B   = 8'h4A;
    localparam logic [7:0] GPC_IDX_P1_DATA  = 8'h4B;
    localparam logic [7:0] GPC_IDX_P2_DATA  = 8'h4C;
    localparam int         GPC_ADDR_W       = 12;
    localparam int         GPC_NCFG         = 7;
    // configuration field positions
    localparam int         GPC_CFG_DIR      = 0;
    localparam int         GPC_CFG_POL      = 1;
    localparam int         GPC_CFG_FN_LO    = 2;
    localparam int         GPC_CFG_OD       = 7;
    localparam logic [1:0] GPC_FN_GPIO      = 2'h0;
    localparam logic [1:0] GPC_FN_ALT       = 2'h1;
    localparam logic [1:0] GPC_FN_EDGE_IRQ  = 2'h2;
    // reset values
    localparam logic [7:0] GPC_CFG_RST_P53  = 8'h00;
    localparam logic [7:0] GPC_CFG_RST      = 8'h01;
    localparam logic [7:0] GPC_DATA_RST     = 8'h00;
    localparam logic [7:0] GPC_P2_MASK      = 8'hF7;
    // axi responses
    localparam logic [1:0] GPC_RESP_OKAY    = 2'h0;
    localparam logic [1:0] GPC_RESP_SLVERR  = 2'h2;

    function automatic logic [GPC_ADDR_W-1:0] gpc_byte_addr(input logic [7:0] idx);
        gpc_byte_addr = {2'h0, idx, 2'h0};
    endfunction
endpackage

//--- hw/gpc_pin_cell.sv
// one configurable pin: direction, polarity, function mux, driver type
`timescale 1ns/1ps
module gpc_pin_cell
    import gpc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] cfg,
    input  wire logic       gpio_out,
    input  wire logic       alt_out,
    input  wire logic       alt_is_out,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe_n,
    output logic            level,
    output logic            edge_evt
);
    logic drive_val;
    logic is_out;
    logic level_reg;
    logic level_next;

    always_comb begin
        // alternate output functions force the pin to drive
        is_out    = (cfg[3:2] == GPC_FN_ALT) ? alt_is_out : !cfg[GPC_CFG_DIR];
        drive_val = ((cfg[3:2] == GPC_FN_ALT) ? alt_out : gpio_out)
                    ^ cfg[GPC_CFG_POL];
        // open drain only pulls low, releases for a one
        if (!is_out) begin
            pin_out  = 1'b1;
            pin_oe_n = 1'b1;
        end else if (cfg[GPC_CFG_OD]) begin
            pin_out  = 1'b0;
            pin_oe_n = drive_val;
        end else begin
            pin_out  = drive_val;
            pin_oe_n = 1'b0;
        end
        level      = pin_in ^ cfg[GPC_CFG_POL];
        level_next = level;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
        end
    end

    // either-edge event, only in the interrupt function
    assign edge_evt = (cfg[3:2] == GPC_FN_EDGE_IRQ) && (level != level_reg);
endmodule // gpc_pin_cell

//--- hw/gpc_axil_slave.sv
// axi4-lite slave front end giving single-cycle register strobes
`timescale 1ns/1ps
module gpc_axil_slave
    import gpc_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [GPC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [GPC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       wr_en,
    output logic [GPC_ADDR_W-1:0]      wr_addr,
    output logic [7:0]                 wr_data,
    input  wire logic                  wr_ok,
    output logic [GPC_ADDR_W-1:0]      rd_addr,
    input  wire logic [7:0]            rd_data,
    input  wire logic                  rd_ok
);
    logic                  aw_have_reg, aw_have_next;
    logic                  w_have_reg, w_have_next;
    logic [GPC_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [7:0]            wdata_reg, wdata_next;
    logic                  wlane_reg, wlane_next;
    logic                  bvalid_reg, bvalid_next;
    logic [1:0]            bresp_reg, bresp_next;
    logic                  rvalid_reg, rvalid_next;
    logic [1:0]            rresp_reg, rresp_next;
    logic [31:0]           rdata_reg, rdata_next;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    // byte lane 0 only carries data; a write without it changes nothing
    assign wr_en   = aw_have_reg && w_have_reg && !bvalid_reg && wlane_reg;
    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign rd_addr = s_axi_araddr;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wlane_next   = wlane_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            wdata_next  = s_axi_wdata[7:0];
            wlane_next  = s_axi_wstrb[0];
        end
        if (aw_have_reg && w_have_reg && !bvalid_reg) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_ok ? GPC_RESP_OKAY : GPC_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = {24'h000000, rd_data};
            rresp_next  = rd_ok ? GPC_RESP_OKAY : GPC_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= GPC_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= GPC_RESP_OKAY;
            rdata_reg   <= 32'h00000000;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wlane_reg   <= wlane_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end
endmodule // gpc_axil_slave

//--- hw/gpc_top.sv
// gpio pin configuration registers for pins 5.3..6.1 and data ports 1 and 2
`timescale 1ns/1ps
// Functional notes
// - config bit 0 high makes the pin an input, low an output.
// - config bit 1 high inverts pin sense both ways.
// - config bits 3:2 pick function; 00 is plain gpio.
// - code 01 on port 5 routes second serial port signals.
// - pin 6.0 code 10 is edge interrupt 4, code 01 first lamp.
// - pin 6.1 code 10 is edge interrupt 5, code 01 second lamp.
// - config bit 7 high gives open-drain, low push-pull.
// - config bits 6:4 reserved, no effect on the pin.
// - pins 5.4 to 6.1 reset config to 0x01.
// - data register 1 bits map to pins 1.0..1.7, reset zero.
// - data register 2 maps pins 2.0-2.2, 2.4-2.7; bit 3 reserved.
// - reserved locations 49 and 4A read as zero.
module gpc_top
    import gpc_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [GPC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [GPC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // pins 5.3..5.7, 6.0, 6.1 in bit order
    input  wire logic [GPC_NCFG-1:0]   cfg_pin_in,
    output logic [GPC_NCFG-1:0]        cfg_pin_out,
    output logic [GPC_NCFG-1:0]        cfg_pin_oe_n,
    // port 1 and port 2 pins
    input  wire logic [7:0]            port1_pin_in,
    output logic [7:0]                 port1_pin_out,
    output logic [7:0]                 port1_pin_oe_n,
    input  wire logic [7:0]            port2_pin_in,
    output logic [7:0]                 port2_pin_out,
    output logic [7:0]                 port2_pin_oe_n,
    // port 1/2 directions come from their own config registers elsewhere
    input  wire logic [7:0]            port1_is_input,
    input  wire logic [7:0]            port2_is_input,
    // second serial port side
    input  wire logic                  serial2_transmit,
    output logic                       serial2_set_ready_n,
    input  wire logic                  serial2_request_send_n,
    output logic                       serial2_clear_send_n,
    input  wire logic                  serial2_terminal_ready_n,
    input  wire logic                  lamp_out_first,
    input  wire logic                  lamp_out_second,
    output logic                       edge_irq4,
    output logic                       edge_irq5
);
    logic [7:0]            cfg_reg  [GPC_NCFG];
    logic [7:0]            cfg_next [GPC_NCFG];
    logic [7:0]            port1_data_reg, port1_data_next;
    logic [7:0]            port2_data_reg, port2_data_next;
    logic                  wr_en;
    logic [GPC_ADDR_W-1:0] wr_addr;
    logic [7:0]            wr_data;
    logic                  wr_ok;
    logic [GPC_ADDR_W-1:0] rd_addr;
    logic [7:0]            rd_data;
    logic                  rd_ok;
    logic [GPC_NCFG-1:0]   alt_out;
    logic [GPC_NCFG-1:0]   alt_is_out;
    logic [GPC_NCFG-1:0]   cfg_level;
    logic [GPC_NCFG-1:0]   cfg_edge;
    logic [7:0]            port1_level;
    logic [7:0]            port2_level;
    logic                  evt4_reg, evt5_reg;

    // config slot of an address, or GPC_NCFG when none
    function automatic int cfg_slot(input logic [GPC_ADDR_W-1:0] a);
        cfg_slot = GPC_NCFG;
        for (int i = 0; i < GPC_NCFG; i++) begin
            if (a == gpc_byte_addr(GPC_IDX_P53_CFG + 8'(i))) begin
                cfg_slot = i;
            end
        end
    endfunction

    gpc_axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // alternate function wiring per pin
    always_comb begin
        alt_out    = '0;
        alt_is_out = '0;
        alt_out[0]    = serial2_transmit;
        alt_is_out[0] = 1'b1;
        alt_out[2]    = serial2_request_send_n;
        alt_is_out[2] = 1'b1;
        alt_out[4]    = serial2_terminal_ready_n;
        alt_is_out[4] = 1'b1;
        alt_out[5]    = lamp_out_first;
        alt_is_out[5] = 1'b1;
        alt_out[6]    = lamp_out_second;
        alt_is_out[6] = 1'b1;
        // input functions: the modem inputs fall back high when not selected
        serial2_set_ready_n  = (cfg_reg[1][3:2] == GPC_FN_ALT) ? cfg_level[1] : 1'b1;
        serial2_clear_send_n = (cfg_reg[3][3:2] == GPC_FN_ALT) ? cfg_level[3] : 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < GPC_NCFG; g++) begin : g_cell
            gpc_pin_cell u_cell (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .cfg        (cfg_reg[g]),
                .gpio_out   (1'b0),
                .alt_out    (alt_out[g]),
                .alt_is_out (alt_is_out[g]),
                .pin_in     (cfg_pin_in[g]),
                .pin_out    (cfg_pin_out[g]),
                .pin_oe_n   (cfg_pin_oe_n[g]),
                .level      (cfg_level[g]),
                .edge_evt   (cfg_edge[g])
            );
        end
    endgenerate

    // port 1 and 2 pins driven from the data registers, push-pull
    always_comb begin
        port1_level    = port1_pin_in;
        port2_level    = port2_pin_in & GPC_P2_MASK;
        port1_pin_out  = port1_data_reg;
        port2_pin_out  = port2_data_reg & GPC_P2_MASK;
        port1_pin_oe_n = port1_is_input;
        port2_pin_oe_n = port2_is_input | ~GPC_P2_MASK;
    end

    // register writes; reserved config bits are stored but steer nothing
    always_comb begin
        int s;
        s = cfg_slot(wr_addr);
        for (int i = 0; i < GPC_NCFG; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        port1_data_next = port1_data_reg;
        port2_data_next = port2_data_reg;
        wr_ok           = 1'b1;
        if (wr_en) begin
            if (s < GPC_NCFG) begin
                cfg_next[s] = wr_data;
            end else if (wr_addr == gpc_byte_addr(GPC_IDX_P1_DATA)) begin
                port1_data_next = wr_data;
            end else if (wr_addr == gpc_byte_addr(GPC_IDX_P2_DATA)) begin
                port2_data_next = wr_data & GPC_P2_MASK;
            end else if (wr_addr == gpc_byte_addr(GPC_IDX_RSVD_A)
                         || wr_addr == gpc_byte_addr(GPC_IDX_RSVD_B)) begin
                wr_ok = 1'b1; // writes to reserved slots are dropped
            end else begin
                wr_ok = 1'b0;
            end
        end
    end

    // reads: inputs show the pin level, outputs the stored value
    always_comb begin
        int s;
        s       = cfg_slot(rd_addr);
        rd_data = 8'h00;
        rd_ok   = 1'b1;
        if (s < GPC_NCFG) begin
            rd_data = cfg_reg[s];
        end else if (rd_addr == gpc_byte_addr(GPC_IDX_P1_DATA)) begin
            rd_data = (port1_is_input & port1_level)
                      | (~port1_is_input & port1_data_reg);
        end else if (rd_addr == gpc_byte_addr(GPC_IDX_P2_DATA)) begin
            rd_data = ((port2_is_input & port2_level)
                      | (~port2_is_input & port2_data_reg)) & GPC_P2_MASK;
        end else if (rd_addr == gpc_byte_addr(GPC_IDX_RSVD_A)
                     || rd_addr == gpc_byte_addr(GPC_IDX_RSVD_B)) begin
            rd_data = 8'h00;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg[0] <= GPC_CFG_RST_P53;
            for (int i = 1; i < GPC_NCFG; i++) begin
                cfg_reg[i] <= GPC_CFG_RST;
            end
            port1_data_reg <= GPC_DATA_RST;
            port2_data_reg <= GPC_DATA_RST;
            evt4_reg       <= 1'b0;
            evt5_reg       <= 1'b0;
        end else begin
            for (int i = 0; i < GPC_NCFG; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
            port1_data_reg <= port1_data_next;
            port2_data_reg <= port2_data_next;
            evt4_reg       <= cfg_edge[5];
            evt5_reg       <= cfg_edge[6];
        end
    end

    assign edge_irq4 = evt4_reg;
    assign edge_irq5 = evt5_reg;
endmodule // gpc_top

//--- sim/gpc_top_props.sv
// bus handshake and pin output checker for the gpio configuration block
`timescale 1ns/1ps
module gpc_top_props
    import gpc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  port1_is_input,
    input wire logic [7:0]  port1_pin_oe_n,
    input wire logic [7:0]  port2_pin_out,
    input wire logic [7:0]  port2_pin_oe_n,
    input wire logic        edge_irq4
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read address taken during answer");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write taken during answer");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_r_upper: assert property (p_r_upper) else $error("read upper bytes not zero");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == GPC_RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read carries data");
    property p_p2_bit3; !port2_pin_out[3] && port2_pin_oe_n[3]; endproperty
    a_p2_bit3: assert property (p_p2_bit3) else $error("port 2 bit 3 driven");
    property p_p1_dir; port1_pin_oe_n == port1_is_input; endproperty
    a_p1_dir: assert property (p_p1_dir) else $error("port 1 enable wrong");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == GPC_RESP_SLVERR);
    c_irq: cover property (edge_irq4);
endmodule // gpc_top_props
bind gpc_top gpc_top_props u_props (.*);

//--- sim/tb_top.sv
// self-checking bench for the gpio configuration and data block
`timescale 1ns/1ps
module tb_top;
    import gpc_pkg::*;
    logic        aclk = 0, aresetn = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        edge_irq4, edge_irq5, serial2_set_ready_n, serial2_clear_send_n;
    logic [6:0]  cfg_pin_in = 0, cfg_pin_out, cfg_pin_oe_n;
    logic [7:0]  port1_pin_in = 0, port2_pin_in = 0, port1_is_input = 0, port2_is_input = 0;
    logic [7:0]  port1_pin_out, port1_pin_oe_n, port2_pin_out, port2_pin_oe_n;
    logic        serial2_transmit = 0, serial2_request_send_n = 1, serial2_terminal_ready_n = 1;
    logic        lamp_out_first = 0, lamp_out_second = 0;
    int          err_count = 0, n_compared = 0, n4 = 0, n5 = 0;
    gpc_top dut (.*);
    always #10 aclk = ~aclk;
    // counted mid-cycle so the pulse is seen settled
    always @(negedge aclk) begin
        n4 += (edge_irq4 === 1'b1);
        n5 += (edge_irq5 === 1'b1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [11:0] ba(input int idx);
        return 12'(idx * 4);
    endfunction
    function automatic logic [1:0] pin_exp(input logic [7:0] c);
        if (c[0]) return 2'h3;
        if (c[7]) return {1'b0, c[1]};
        return {c[1], 1'b0};
    endfunction
    // handshake judged mid-cycle: same values the next rising edge samples
    task automatic xfer(input bit w, input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tr, dn;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
        end
        for (int n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            dn = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
            rd = s_axi_rdata;
            rs = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            // ready raised after a random wait, then held until the answer
            s_axi_bready <= w && !dn && (s_axi_bready || $urandom_range(1));
            s_axi_rready <= !w && !dn && (s_axi_rready || $urandom_range(1));
            if (dn) break;
        end
        if (!dn) err_count++;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        xfer(0, a, 8'h0);
        check(rd, {24'h0, e});
        check(rs, GPC_RESP_OKAY);
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic reset_chk();
        @(negedge aclk);
        check(cfg_pin_oe_n, 7'h7E);
        check(cfg_pin_out, 7'h7E);
        for (int i = 0; i < 7; i++) rchk(ba(GPC_IDX_P53_CFG + i), i == 0 ? 8'h00 : 8'h01);
        rchk(ba(GPC_IDX_P1_DATA), 8'h00);
        rchk(ba(GPC_IDX_P2_DATA), 8'h00);
    endtask
    initial begin
        logic [7:0] c, v;
        int i;
        void'($urandom(32'h707aa8ec));
        do_reset();
        reset_chk();
        rchk(ba(GPC_IDX_RSVD_A), 8'h00);
        xfer(1, ba(GPC_IDX_RSVD_B), 8'hFF);
        check(rs, GPC_RESP_OKAY);
        rchk(ba(GPC_IDX_RSVD_B), 8'h00);
        s_axi_wstrb <= 4'h0;
        xfer(1, ba(GPC_IDX_P1_DATA), 8'hA5);
        s_axi_wstrb <= 4'hF;
        check(rs, GPC_RESP_OKAY);
        rchk(ba(GPC_IDX_P1_DATA), 8'h00);
        xfer(0, 12'h004, 8'h00);
        check(rd, 32'h0);
        check(rs, GPC_RESP_SLVERR);
        // reserved bits randomised too: they must not move the pin
        repeat (40) begin
            i = $urandom_range(6);
            c = $urandom;
            if (c[3:2] == 2'h1) c[3:2] = 2'h0;
            if (i > 4 && c[3:2] == 2'h2) c[3:2] = 2'h3;
            xfer(1, ba(GPC_IDX_P53_CFG + i), c);
            xfer(0, ba(GPC_IDX_P53_CFG + i), 8'h0);
            check(rd & 32'h8F, c & 8'h8F);
            check({cfg_pin_out[i], cfg_pin_oe_n[i]}, pin_exp(c));
        end
        for (int p = 0; p < 2; p++) begin
            for (int j = 0; j < 5; j++) xfer(1, ba(GPC_IDX_P53_CFG + j), j % 2 ? 8'h05 | (p << 1) : 8'h04);
            repeat (4) begin
                v = $urandom;
                @(posedge aclk);
                {serial2_terminal_ready_n, serial2_request_send_n, serial2_transmit} <= v[2:0];
                cfg_pin_in[1] <= v[3];
                cfg_pin_in[3] <= v[4];
                @(negedge aclk);
                check({cfg_pin_out[4], cfg_pin_out[2], cfg_pin_out[0]}, v[2:0]);
                check({cfg_pin_oe_n[4], cfg_pin_oe_n[2], cfg_pin_oe_n[0]}, 3'h0);
                check({serial2_clear_send_n, serial2_set_ready_n}, v[4:3] ^ {2{p[0]}});
            end
        end
        xfer(1, ba(GPC_IDX_P54_CFG), 8'h01);
        check(serial2_set_ready_n, 1'b1);
        xfer(1, ba(GPC_IDX_P60_CFG), 8'h04);
        xfer(1, ba(GPC_IDX_P61_CFG), 8'h84);
        repeat (4) begin
            v = $urandom;
            @(posedge aclk);
            {lamp_out_second, lamp_out_first} <= v[1:0];
            @(negedge aclk);
            check({cfg_pin_out[5], cfg_pin_oe_n[5]}, {v[0], 1'b0});
            check({cfg_pin_out[6], cfg_pin_oe_n[6]}, {1'b0, v[1]});
        end
        xfer(1, ba(GPC_IDX_P60_CFG), 8'h09);
        xfer(1, ba(GPC_IDX_P61_CFG), 8'h0B);
        repeat (3) @(posedge aclk);
        for (int k = 0; k < 6; k++) begin
            @(posedge aclk);
            n4 = 0;
            n5 = 0;
            cfg_pin_in[5 + k % 2] <= ~cfg_pin_in[5 + k % 2];
            repeat (5) @(posedge aclk);
            check(n4, k % 2 == 0);
            check(n5, k % 2);
        end
        repeat (6) begin
            v = $urandom;
            xfer(1, ba(GPC_IDX_P1_DATA), v);
            xfer(1, ba(GPC_IDX_P2_DATA), ~v);
            check({port2_pin_out, port1_pin_out}, {~v & 8'hF7, v});
            rchk(ba(GPC_IDX_P1_DATA), v);
            rchk(ba(GPC_IDX_P2_DATA), ~v & 8'hF7);
        end
        @(posedge aclk);
        port1_is_input <= 8'hFF;
        port2_is_input <= 8'hFF;
        repeat (4) begin
            v = $urandom;
            @(posedge aclk);
            port1_pin_in <= v;
            port2_pin_in <= ~v;
            // pin inputs may be synchronised before they reach the read path
            repeat (3) @(posedge aclk);
            rchk(ba(GPC_IDX_P1_DATA), v);
            rchk(ba(GPC_IDX_P2_DATA), ~v & 8'hF7);
        end
        @(posedge aclk);
        port1_is_input <= 8'h00;
        port2_is_input <= 8'h00;
        do_reset();
        reset_chk();
        summarize();
    end
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule // tb_top
